//--- src/csr_pkg.sv
// Purpose: shared constants and types for the core status register set
// Assumes: one clock, synchronous active low reset
// Notes:   byte offsets are direct addresses in the upper half of the map
package csr_pkg;

  localparam logic [7:0] CSR_ADDR_STACK   = 8'h81;
  localparam logic [7:0] CSR_ADDR_IDX_LO  = 8'h82;
  localparam logic [7:0] CSR_ADDR_IDX_HI  = 8'h83;
  localparam logic [7:0] CSR_ADDR_STATUS  = 8'hd0;
  localparam logic [7:0] CSR_ADDR_WORK    = 8'he0;
  localparam logic [7:0] CSR_ADDR_AUX     = 8'hf0;

  localparam logic [7:0] CSR_RST_STACK    = 8'h07;
  localparam logic [7:0] CSR_RST_IDX      = 8'h00;
  localparam logic [7:0] CSR_RST_STATUS   = 8'h00;
  localparam logic [7:0] CSR_RST_WORK     = 8'h00;
  localparam logic [7:0] CSR_RST_AUX      = 8'h00;

  // status word bit positions
  localparam int CSR_B_CARRY  = 7;
  localparam int CSR_B_HALF   = 6;
  localparam int CSR_B_USER   = 5;
  localparam int CSR_B_BANK_H = 4;
  localparam int CSR_B_BANK_L = 3;
  localparam int CSR_B_RANGE  = 2;
  localparam int CSR_B_PARITY = 0;

  // bits that firmware may change; bit 1 unused, parity owned by hardware
  localparam logic [7:0] CSR_STATUS_WMASK = 8'hfc;

  // direct addresses from here up select the special-function space
  localparam logic [7:0] CSR_SFR_BASE     = 8'h80;

  typedef enum logic [2:0] {
    CSR_OP_NONE,
    CSR_OP_ADD,
    CSR_OP_ADDC,
    CSR_OP_SUBB,
    CSR_OP_MUL,
    CSR_OP_DIV
  } csr_op_t;

endpackage : csr_pkg

//--- src/csr_arith_unit.sv
// Purpose: arithmetic results and flag values for one datapath operation
// Assumes: purely combinational, read by the register set on the same clock
// Notes:   divide by zero leaves both operands unchanged
`timescale 1ns/1ps
module csr_arith_unit
  import csr_pkg::*;
(
  input  wire csr_op_t    op_in,
  input  wire logic [7:0] work_in,
  input  wire logic [7:0] src_in,
  input  wire logic [7:0] aux_in,
  input  wire logic       carry_in,
  output logic [7:0]      work_res_out,
  output logic [7:0]      aux_res_out,
  output logic            carry_out,
  output logic            half_out,
  output logic            range_out,
  output logic            upd_half_out,
  output logic            upd_other_out
);

  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;
  logic        cin;

  always_comb begin
    cin           = (op_in == CSR_OP_NONE || op_in == CSR_OP_ADD) ? 1'b0
                                                                  : carry_in;
    sum9          = 9'h000;
    nib5          = 5'h00;
    prod          = 16'(work_in) * 16'(aux_in);
    work_res_out  = work_in;
    aux_res_out   = aux_in;
    carry_out     = 1'b0;
    half_out      = 1'b0;
    range_out     = 1'b0;
    upd_half_out  = 1'b0;
    upd_other_out = 1'b1;
    unique case (op_in)
      CSR_OP_ADD, CSR_OP_ADDC: begin
        sum9         = {1'b0, work_in} + {1'b0, src_in} + {8'h00, cin};
        nib5         = {1'b0, work_in[3:0]} + {1'b0, src_in[3:0]}
                       + {4'h0, cin};
        work_res_out = sum9[7:0];
        carry_out    = sum9[8];                     // see [RULE7]
        half_out     = nib5[4];                     // see [RULE8]
        upd_half_out = 1'b1;
        range_out    = (work_in[7] == src_in[7])
                       && (sum9[7] != work_in[7]);  // see [RULE11]
      end
      CSR_OP_SUBB: begin
        sum9         = {1'b0, work_in} - {1'b0, src_in} - {8'h00, cin};
        nib5         = {1'b0, work_in[3:0]} - {1'b0, src_in[3:0]}
                       - {4'h0, cin};
        work_res_out = sum9[7:0];
        carry_out    = sum9[8];                     // see [RULE7]
        half_out     = nib5[4];                     // see [RULE8]
        upd_half_out = 1'b1;
        range_out    = (work_in[7] != src_in[7])
                       && (sum9[7] != work_in[7]);  // see [RULE11]
      end
      CSR_OP_MUL: begin
        work_res_out = prod[7:0];                   // see [RULE5]
        aux_res_out  = prod[15:8];
        range_out    = |prod[15:8];                 // see [RULE11]
      end
      CSR_OP_DIV: begin
        if (aux_in == 8'h00) begin
          range_out = 1'b1;                         // see [RULE11]
        end else begin
          work_res_out = work_in / aux_in;          // see [RULE5]
          aux_res_out  = work_in % aux_in;
        end
      end
      CSR_OP_NONE: begin
        upd_other_out = 1'b0;
      end
      default: begin
        upd_other_out = 1'b0;
      end
    endcase
  end

endmodule : csr_arith_unit

//--- src/csr_core_regs.sv
// Purpose: core special-function registers with datapath and firmware access
// Assumes: one clock, synchronous active low reset, requests from core logic
// Notes:   byte and bit reads answer one cycle after the request
//
// How it works
// [RULE1] firmware stays off unimplemented addresses; they read zero, no hit
// [RULE2] stack pointer is eight bits and resets to 07h
// [RULE3] firmware may write any value to the stack pointer
// [RULE4] index pointer is high and low byte, also loaded as sixteen bits
// [RULE5] aux register holds multiply and divide operands and results
// [RULE6] work register sits at e0h and resets to zero
// [RULE7] carry is set on carry or borrow, cleared otherwise
// [RULE8] half carry follows the low nibble carry or borrow
// [RULE9] user flag at bit 5 is touched only by firmware
// [RULE10] two bank bits select register bank base 00h, 08h, 10h or 18h
// [RULE11] range error on signed overflow, big product or divide by zero
// [RULE12] parity bit tracks odd ones in the work register every cycle
// [RULE13] status word is bit addressable, bit 1 unused
// [RULE14] status word resets to all zeros
// [RULE15] direct upper addresses hit registers, indirect go to upper ram
// [RULE16] registers at addresses ending 0h or 8h are bit addressable
// [RULE17] push increments before writing, pop reads before decrementing
`timescale 1ns/1ps
module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  // byte access on the internal address
  input  wire logic [7:0]  addr_in,
  input  wire logic        indirect_in,
  input  wire logic        rd_in,
  input  wire logic        wr_in,
  input  wire logic [7:0]  wdata_in,
  // bit access
  input  wire logic [7:0]  bit_addr_in,
  input  wire logic        bit_rd_in,
  input  wire logic        bit_wr_in,
  input  wire logic        bit_wdata_in,
  // datapath
  input  wire csr_op_t     op_in,
  input  wire logic [7:0]  op_src_in,
  input  wire logic        work_ld_in,
  input  wire logic [7:0]  work_ld_data_in,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  input  wire logic        index_ld_in,
  input  wire logic [15:0] index_ld_data_in,
  input  wire logic        index_inc_in,
  // results
  output logic [7:0]       rdata_out,
  output logic             rdata_bit_out,
  output logic             sfr_hit_out,
  output logic             upper_ram_sel_out,
  output logic [7:0]       work_out,
  output logic [7:0]       aux_out,
  output logic [7:0]       stack_ptr_out,
  output logic [15:0]      mem_index_out,
  output logic [7:0]       status_word_out,
  output logic [7:0]       bank_base_out
);

  logic [7:0] work_q, work_d, aux_q, aux_d, sp_q, sp_d;
  logic [7:0] lo_q, lo_d, hi_q, hi_d, st_q, st_d;
  logic [7:0] rdata_q, rdata_d, base_q, base_d;
  logic       rbit_q, rbit_d, hit_q, hit_d, upper_q, upper_d;
  logic [7:0] a_res, b_res;
  logic       a_cy, a_half, a_range, a_upd_half, a_upd;
  logic       direct_sfr, byte_rd_ok;
  logic [7:0] bit_byte, rd_byte, cur_bit_byte;
  logic [15:0] idx_inc;

  csr_arith_unit u_arith (
    .op_in         (op_in),
    .work_in       (work_q),
    .src_in        (op_src_in),
    .aux_in        (aux_q),
    .carry_in      (st_q[CSR_B_CARRY]),
    .work_res_out  (a_res),
    .aux_res_out   (b_res),
    .carry_out     (a_cy),
    .half_out      (a_half),
    .range_out     (a_range),
    .upd_half_out  (a_upd_half),
    .upd_other_out (a_upd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read decode

  function automatic logic [7:0] csr_sel(input logic [7:0] a,
                                          input logic [7:0] wk,
                                          input logic [7:0] ax,
                                          input logic [7:0] sp,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi,
                                          input logic [7:0] st);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      CSR_ADDR_STACK:  v = sp;
      CSR_ADDR_IDX_LO: v = lo;
      CSR_ADDR_IDX_HI: v = hi;
      CSR_ADDR_STATUS: v = st;
      CSR_ADDR_WORK:   v = wk;
      CSR_ADDR_AUX:    v = ax;
      default:         v = 8'h00;          // see [RULE1]
    endcase
    return v;
  endfunction : csr_sel

  function automatic logic csr_known(input logic [7:0] a);
    return a == CSR_ADDR_STACK || a == CSR_ADDR_IDX_LO
        || a == CSR_ADDR_IDX_HI || a == CSR_ADDR_STATUS
        || a == CSR_ADDR_WORK || a == CSR_ADDR_AUX;
  endfunction : csr_known

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    work_d  = work_q;
    aux_d   = aux_q;
    sp_d    = sp_q;
    lo_d    = lo_q;
    hi_d    = hi_q;
    st_d    = st_q;
    idx_inc = {hi_q, lo_q} + 16'h0001;
    direct_sfr = !indirect_in && (addr_in >= CSR_SFR_BASE);   // see [RULE15]
    upper_d = (rd_in || wr_in) && indirect_in
              && (addr_in >= CSR_SFR_BASE);                   // see [RULE15]
    byte_rd_ok = rd_in && direct_sfr && csr_known(addr_in);
    rd_byte = csr_sel(addr_in, work_q, aux_q, sp_q, lo_q, hi_q, st_q);
    rdata_d = byte_rd_ok ? rd_byte : 8'h00;
    // bit address maps to the byte ending 0h or 8h
    bit_byte = {bit_addr_in[7:3], 3'b000};                    // see [RULE16]
    cur_bit_byte = csr_sel(bit_byte, work_q, aux_q, sp_q, lo_q, hi_q, st_q);
    rbit_d  = bit_rd_in && bit_addr_in[7] && csr_known(bit_byte)
              && cur_bit_byte[bit_addr_in[2:0]];
    hit_d   = byte_rd_ok || (wr_in && direct_sfr && csr_known(addr_in))
              || ((bit_rd_in || bit_wr_in) && bit_addr_in[7]
                  && csr_known(bit_byte));

    // datapath
    if (work_ld_in) begin
      work_d = work_ld_data_in;
    end
    if (a_upd) begin
      work_d = a_res;
      aux_d  = b_res;                                          // see [RULE5]
      st_d[CSR_B_CARRY] = a_cy;                                // see [RULE7]
      st_d[CSR_B_RANGE] = a_range;                             // see [RULE11]
      if (a_upd_half) begin
        st_d[CSR_B_HALF] = a_half;                             // see [RULE8]
      end
    end
    if (push_in && !pop_in) begin
      sp_d = sp_q + 8'h01;                                     // see [RULE17]
    end else if (pop_in && !push_in) begin
      sp_d = sp_q - 8'h01;                                     // see [RULE17]
    end
    if (index_ld_in) begin
      {hi_d, lo_d} = index_ld_data_in;                         // see [RULE4]
    end else if (index_inc_in) begin
      {hi_d, lo_d} = idx_inc;                                  // see [RULE4]
    end

    // firmware byte write, applied after the datapath
    if (wr_in && direct_sfr) begin
      unique case (addr_in)
        CSR_ADDR_STACK:  sp_d   = wdata_in;                    // see [RULE3]
        CSR_ADDR_IDX_LO: lo_d   = wdata_in;                    // see [RULE4]
        CSR_ADDR_IDX_HI: hi_d   = wdata_in;                    // see [RULE4]
        CSR_ADDR_STATUS: st_d   = (wdata_in & CSR_STATUS_WMASK)
                                  | (st_d & ~CSR_STATUS_WMASK);
        CSR_ADDR_WORK:   work_d = wdata_in;                    // see [RULE6]
        CSR_ADDR_AUX:    aux_d  = wdata_in;                    // see [RULE5]
        default:         ;                                     // see [RULE1]
      endcase
    end

    // firmware bit write
    if (bit_wr_in && bit_addr_in[7]) begin
      unique case (bit_byte)
        CSR_ADDR_STATUS: begin
          if (CSR_STATUS_WMASK[bit_addr_in[2:0]]) begin
            st_d[bit_addr_in[2:0]] = bit_wdata_in;             // see [RULE13]
          end
        end
        CSR_ADDR_WORK: work_d[bit_addr_in[2:0]] = bit_wdata_in;
        CSR_ADDR_AUX:  aux_d[bit_addr_in[2:0]]  = bit_wdata_in;
        default:       ;
      endcase
    end

    // unused bit stays zero; parity follows the new work value
    st_d[1] = 1'b0;                                            // see [RULE13]
    st_d[CSR_B_PARITY] = ^work_d;                              // see [RULE12]
    // user flag only changes through the firmware paths above, see [RULE9]
    base_d = {3'b000, st_d[CSR_B_BANK_H], st_d[CSR_B_BANK_L],
              3'b000};                                         // see [RULE10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      work_q  <= CSR_RST_WORK;                                 // see [RULE6]
      aux_q   <= CSR_RST_AUX;
      sp_q    <= CSR_RST_STACK;                                // see [RULE2]
      lo_q    <= CSR_RST_IDX;
      hi_q    <= CSR_RST_IDX;
      st_q    <= CSR_RST_STATUS;                               // see [RULE14]
      rdata_q <= 8'h00;
      rbit_q  <= 1'b0;
      hit_q   <= 1'b0;
      upper_q <= 1'b0;
      base_q  <= 8'h00;
    end else begin
      work_q  <= work_d;
      aux_q   <= aux_d;
      sp_q    <= sp_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
      st_q    <= st_d;
      rdata_q <= rdata_d;
      rbit_q  <= rbit_d;
      hit_q   <= hit_d;
      upper_q <= upper_d;
      base_q  <= base_d;
    end
  end

  assign rdata_out         = rdata_q;
  assign rdata_bit_out     = rbit_q;
  assign sfr_hit_out       = hit_q;
  assign upper_ram_sel_out = upper_q;
  assign work_out          = work_q;
  assign aux_out           = aux_q;
  assign stack_ptr_out     = sp_q;
  assign mem_index_out     = {hi_q, lo_q};
  assign status_word_out   = st_q;
  assign bank_base_out     = base_q;

endmodule : csr_core_regs

//--- test/csr_core_regs_asserts.sv
// Purpose: checker for the core register set
// Assumes: bound to csr_core_regs, one clock
// Notes:   reset check ignores the disable
`timescale 1ns/1ps
module csr_regs_chk
  import csr_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] addr_in,
  input wire logic       indirect_in,
  input wire logic       rd_in,
  input wire logic       wr_in,
  input wire logic       bit_wr_in,
  input wire csr_op_t    op_in,
  input wire logic       push_in,
  input wire logic       pop_in,
  input wire logic [7:0] rdata_out,
  input wire logic       sfr_hit_out,
  input wire logic       upper_ram_sel_out,
  input wire logic [7:0] work_out,
  input wire logic [7:0] stack_ptr_out,
  input wire logic [7:0] status_word_out,
  input wire logic [7:0] bank_base_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic fw_w;
  assign fw_w = wr_in | bit_wr_in;
  ////////////////////////////////////////
  rst_val_a: assert property (disable iff (1'b0)
    !nrst_in |=> stack_ptr_out == 8'h07 && status_word_out == 8'h00)
    else $error("reset values wrong");
  parity_a: assert property (status_word_out[0] == ^work_out)
    else $error("parity bit wrong");
  bank_map_a: assert property (
    bank_base_out == {3'h0, status_word_out[4:3], 3'h0})
    else $error("bank base wrong");
  stack_push_a: assert property (push_in && !pop_in && !fw_w
    |=> stack_ptr_out == $past(stack_ptr_out) + 8'h01)
    else $error("push did not increment");
  stack_pop_a: assert property (pop_in && !push_in && !fw_w
    |=> stack_ptr_out == $past(stack_ptr_out) - 8'h01)
    else $error("pop did not decrement");
  stack_read_a: assert property (rd_in && !wr_in
    && !indirect_in && addr_in == CSR_ADDR_STACK |=> sfr_hit_out
    && rdata_out == $past(stack_ptr_out)) else $error("stack read wrong");
  upper_ram_a: assert property ((rd_in || wr_in) && indirect_in
    && addr_in[7] |=> upper_ram_sel_out && !sfr_hit_out)
    else $error("indirect access hit registers");
  user_keep_a: assert property (op_in != CSR_OP_NONE && !fw_w
    |=> $stable(status_word_out[5])) else $error("user flag changed");
  work_hit_a: assert property (wr_in && !indirect_in
    && addr_in == CSR_ADDR_WORK |=> sfr_hit_out)
    else $error("work write missed");
  push_c: cover property (push_in && !pop_in);
  mul_c: cover property (op_in == CSR_OP_MUL);
  upper_c: cover property (indirect_in && rd_in);
endmodule : csr_regs_chk

bind csr_core_regs csr_regs_chk i_chk (
  .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
  .indirect_in(indirect_in), .rd_in(rd_in), .wr_in(wr_in),
  .bit_wr_in(bit_wr_in), .op_in(op_in), .push_in(push_in),
  .pop_in(pop_in), .rdata_out(rdata_out), .sfr_hit_out(sfr_hit_out),
  .upper_ram_sel_out(upper_ram_sel_out), .work_out(work_out),
  .stack_ptr_out(stack_ptr_out), .status_word_out(status_word_out),
  .bank_base_out(bank_base_out));

//--- test/csr_dp_model.sv
// Purpose: datapath side model driving the register set
// Assumes: changes its outputs on the falling edge
// Notes:   a step holds its values until the next step
`timescale 1ns/1ps
module csr_dp_model
  import csr_pkg::*;
(
  input  wire logic   clk_in,
  output csr_op_t     op_out,
  output logic [7:0]  src_out,
  output logic [4:0]  ctl_out,
  output logic [15:0] index_data_out
);
  initial begin
    op_out = CSR_OP_NONE;
    {src_out, ctl_out, index_data_out} = '0;
  end
  // ctl: work load, push, pop, index load, index increment
  task automatic step(input csr_op_t o, input logic [7:0] s,
                      input logic [4:0] c, input logic [15:0] d);
    @(negedge clk_in);
    op_out         = o;
    src_out        = s;
    ctl_out        = c;
    index_data_out = d;
  endtask : step
endmodule : csr_dp_model

//--- test/core_sfr_status_regs_tb.sv
// Purpose: self-checking bench for the core register set
// Assumes: inputs change on the falling edge
// Notes:   reads are checked against a queue of expected values
`timescale 1ns/1ps
module core_sfr_status_regs_tb
  import csr_pkg::*;
;
  localparam logic [4:0] RD = 5'h10, WR = 5'h08, BR = 5'h04, BW = 5'h02;
  localparam logic [4:0] IN = 5'h01;
  logic        clk_in = 1'b0;
  logic        nrst_in, indirect_in, rd_in, wr_in, bit_rd_in, bit_wr_in;
  logic        bit_wdata_in, rdata_bit_out, sfr_hit_out;
  logic        rd_q = 1'b0;
  logic        brd_q = 1'b0;
  logic [7:0]  addr_in, wdata_in, bit_addr_in, rdata_out, src, aux_o;
  logic [4:0]  ctl;
  logic [15:0] idx_d, idx_o;
  csr_op_t     op;
  logic [8:0]  s, e, exp_q[$];
  logic [7:0]  w[6];
  logic [55:0] t;
  logic [7:0]  ad[6] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0, 8'hf0};
  logic [7:0]  rv[6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [55:0] at[10] = '{56'h17f01001800065, 56'h2ff000010000e0,
    56'h30001000ff00e0, 56'h380010007f0065, 56'h30502001020021,
    56'h41000101000124, 56'h40f00110ff0020, 56'h564000710e0221,
    56'h55500001550024, 56'h10808001100061};
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  int          i, r;
  always #2.5 clk_in = ~clk_in;
  csr_dp_model i_dp (.clk_in(clk_in), .op_out(op), .src_out(src),
    .ctl_out(ctl), .index_data_out(idx_d));
  csr_core_regs i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .indirect_in(indirect_in), .rd_in(rd_in),
    .wr_in(wr_in), .wdata_in(wdata_in), .bit_addr_in(bit_addr_in),
    .bit_rd_in(bit_rd_in), .bit_wr_in(bit_wr_in),
    .bit_wdata_in(bit_wdata_in), .op_in(op), .op_src_in(src),
    .work_ld_in(ctl[4]), .work_ld_data_in(src), .push_in(ctl[3]),
    .pop_in(ctl[2]), .index_ld_in(ctl[1]), .index_ld_data_in(idx_d),
    .index_inc_in(ctl[0]), .rdata_out(rdata_out),
    .rdata_bit_out(rdata_bit_out), .sfr_hit_out(sfr_hit_out),
    .upper_ram_sel_out(), .work_out(), .aux_out(aux_o), .stack_ptr_out(),
    .mem_index_out(idx_o), .status_word_out(), .bank_base_out());
  ////////////////////////////////////////
  task automatic check(input logic [15:0] sn, input logic [15:0] ex);
    checked++;
    if (sn !== ex) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, sn, ex);
    end
  endtask : check
  task automatic complete_run();
    if (exp_q.size() != 0) n_fail++;
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic acc(input logic [4:0] k, input logic [7:0] a,
                     input logic [7:0] d, input logic [8:0] ex);
    @(negedge clk_in);
    {rd_in, wr_in, bit_rd_in, bit_wr_in, indirect_in} = k;
    addr_in      = a;
    bit_addr_in  = a;
    wdata_in     = d;
    bit_wdata_in = d[0];
    if (k[4] | k[2]) exp_q.push_back(ex);
  endtask : acc
  task automatic dp(input logic [4:0] c, input logic [15:0] d);
    i_dp.step(CSR_OP_NONE, d[7:0], c, d);
  endtask : dp
  always @(posedge clk_in) begin
    rd_q  <= rd_in | bit_rd_in;
    brd_q <= bit_rd_in;
    cyc   <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  always @(negedge clk_in) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      s = brd_q ? {sfr_hit_out, 7'h0, rdata_bit_out}
                : {sfr_hit_out, rdata_out};
      check(16'(s), 16'(e));
    end
  end
  ////////////////////////////////////////
  initial begin
    {nrst_in, indirect_in, rd_in, wr_in, bit_rd_in, bit_wr_in} = '0;
    {bit_wdata_in, addr_in, wdata_in, bit_addr_in} = '0;
    r = $urandom(32'h29f1);
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    for (i = 0; i < 6; i++) acc(RD, ad[i], 0, {1'b1, rv[i]});
    acc(WR, 8'h84, 8'hff, 0);
    acc(RD, 8'h84, 0, 9'h000);
    acc(WR | IN, 8'h81, 8'h5a, 0);
    acc(RD | IN, 8'h81, 0, 9'h000);
    acc(RD, 8'h81, 0, 9'h107);
    for (i = 0; i < 6; i++) begin
      w[i] = 8'($urandom());
      acc(WR, ad[i], w[i], 0);
    end
    w[3] = (w[3] & 8'hfc) | {7'h0, ^w[4]};
    for (i = 0; i < 6; i++) acc(RD, ad[i], 0, {1'b1, w[i]});
    acc(0, 0, 0, 0);
    dp(5'h08, 0);
    dp(5'h08, 0);
    dp(5'h0c, 0);
    dp(5'h04, 0);
    dp(5'h02, 16'h12ff);
    dp(5'h01, 0);
    dp(5'h00, 0);
    check(idx_o, 16'h1300);
    acc(RD, 8'h81, 0, {1'b1, w[0] + 8'h01});
    acc(RD, 8'h83, 0, 9'h113);
    acc(RD, 8'h82, 0, 9'h100);
    acc(0, 0, 0, 0);
    dp(5'h03, 16'h00ff);
    dp(5'h00, 0);
    check(idx_o, 16'h00ff);
    acc(RD, 8'h82, 0, 9'h1ff);
    foreach (at[j]) begin
      t = at[j];
      acc(WR, 8'hd0, {t[24], 7'h20}, 0);
      acc(WR, 8'he0, t[51:44], 0);
      acc(WR, 8'hf0, t[35:28], 0);
      acc(0, 0, 0, 0);
      i_dp.step(csr_op_t'(t[54:52]), t[43:36], 5'h00, 16'h0);
      dp(5'h00, 0);
      check(16'(aux_o), 16'(t[15:8]));
      acc(RD, 8'he0, 0, {1'b1, t[23:16]});
      acc(RD, 8'hf0, 0, {1'b1, t[15:8]});
      acc(RD, 8'hd0, 0, {1'b1, t[7:0] | 8'h20});
    end
    acc(0, 0, 0, 0);
    dp(5'h10, 0);
    dp(5'h00, 0);
    acc(WR, 8'hd0, 8'h00, 0);
    acc(BW, 8'hd5, 8'h01, 0);
    acc(BW, 8'hd1, 8'h01, 0);
    for (i = 0; i < 4; i++) begin
      acc(BW, 8'hd4, 8'(i >> 1), 0);
      acc(BW, 8'hd3, 8'(i), 0);
      acc(BR, 8'hd4, 0, {8'h80, i[1]});
      acc(RD, 8'hd0, 0, {4'h9, i[1:0], 3'h0});
    end
    acc(0, 0, 0, 0);
    // second reset in mid-run
    nrst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    nrst_in = 1'b1;
    acc(RD, 8'h81, 0, 9'h107);
    acc(RD, 8'hd0, 0, 9'h100);
    acc(0, 0, 0, 0);
    repeat (2) @(negedge clk_in);
    complete_run();
  end
endmodule : core_sfr_status_regs_tb
